// ### pkg/fault_summary_pkg.sv
// Notes on behaviour
// RULE_01 - fault summary at offset 4, resets to 0347
// RULE_02 - bit 15 flags wire heating fault
// RULE_03 - latch mode holds channel bits until detail read
// RULE_04 - bit 14 flags low power fault exit
// RULE_05 - bit 13 flags channel thermal shutdown
// RULE_06 - bit 12 flags overcurrent turn-off
// RULE_07 - bit 11 flags off-state short to battery
// RULE_08 - bit 10 flags open load on/off
// RULE_09 - bit 9 flags any supply undervoltage, resets 1
// RULE_10 - bit 8 is OR of bits 7..0; latch mode holds it until a global or summary read
// RULE_11 - bit 7 fallback mode, write one clears
// RULE_12 - bit 6 set by power-on, read clears
// RULE_13 - bit 4 flags serial frame errors
// RULE_14 - bit 3 flags serial watchdog timeout
// RULE_15 - bits 4,3 always latched, clear after read
// RULE_16 - bit 2 core lockout, read clears, resets 1
// RULE_17 - bit 1 battery warning, read clears, resets 1
// RULE_18 - bit 0 battery undervoltage, read clears, resets 1
// RULE_19 - bit 5 reserved, reads zero
// RULE_20 - serial error mask blocks bit 4
// RULE_21 - watchdog mask blocks bit 3
// RULE_22 - without latching, bits follow live condition; bits 7, 4 and 3 still hold until cleared and bit 6 until a read
// RULE_23 - read with fault present keeps bit set
package fault_summary_pkg;
    localparam logic [7:0] FAULT_SUMMARY_ADDR = 8'h04;
    localparam logic [15:0] FAULT_SUMMARY_RESET = 16'h0347;
    localparam int BIT_WIRE_HEAT = 15;
    localparam int BIT_LPM_EXIT = 14;
    localparam int BIT_THERMAL = 13;
    localparam int BIT_OVERCURRENT = 12;
    localparam int BIT_SHORT_BAT = 11;
    localparam int BIT_OPEN_LOAD = 10;
    localparam int BIT_SUPPLY = 9;
    localparam int BIT_GLOBAL = 8;
    localparam int BIT_FALLBACK = 7;
    localparam int BIT_POR = 6;
    localparam int BIT_SERIAL_ERR = 4;
    localparam int BIT_WATCHDOG = 3;
    localparam int BIT_CORE_UV = 2;
    localparam int BIT_BAT_WARN = 1;
    localparam int BIT_BAT_UV = 0;
    localparam int NUM_CHAN_BITS = 7;
    localparam int NUM_GLOBAL_BITS = 6;

    // live conditions from the detection circuits
    typedef struct packed {
        logic wire_heat;
        logic lpm_exit;
        logic thermal;
        logic overcurrent;
        logic short_bat;
        logic open_load;
        logic internal_uv;
    } chan_cond_t;

    typedef struct packed {
        logic core_uv;
        logic bat_warn;
        logic bat_uv;
        logic serial_err;
        logic watchdog_to;
        logic fallback;
    } glob_cond_t;

    // register access strobes, one cycle each
    typedef struct packed {
        logic summary_rd;
        logic summary_wr;
        logic [15:0] wdata;
        logic chan_detail_rd;
        logic global_rd;
    } reg_access_t;
endpackage

// ### rtl/fault_flag_cell.sv
// one status flag: set wins over clear, clear only when condition gone
module fault_flag_cell
    import fault_summary_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cond,
    input wire logic latch_en,
    input wire logic clear_req,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;

    always_comb begin
        if (!latch_en) begin
            flag_nxt = cond; // see RULE_22
        end else if (cond) begin
            flag_nxt = 1'b1; // see RULE_23
        end else if (clear_req) begin
            flag_nxt = 1'b0; // see RULE_03
        end else begin
            flag_nxt = flag_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_r <= RESET_VAL;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;

    a_set_wins: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_23
        latch_en && cond |=> flag_r)
        else $error("flag not set while condition present");
endmodule

// ### rtl/fault_summary_status_register.sv
// fault summary word; reads return the value before the read's clearing
module fault_summary_status_register
    import fault_summary_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire chan_cond_t chan_cond,
    input wire glob_cond_t glob_cond,
    input wire reg_access_t acc,
    input wire logic fault_latch_select,
    input wire logic serial_error_mask,
    input wire logic watchdog_error_mask,
    output logic [15:0] fault_summary_status
);
    logic [NUM_CHAN_BITS-1:0] chan_cond_vec;
    logic [NUM_CHAN_BITS-1:0] chan_flag;
    logic [2:0] sup_flag;
    logic [2:0] sup_cond;
    logic serial_flag_r;
    logic serial_flag_nxt;
    logic wd_flag_r;
    logic wd_flag_nxt;
    logic fallback_r;
    logic fallback_nxt;
    logic por_r;
    logic por_nxt;
    logic global_r;
    logic global_nxt;
    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic global_clear;
    logic serial_cond;
    logic wd_cond;

    assign chan_cond_vec = {chan_cond.wire_heat, chan_cond.lpm_exit, chan_cond.thermal,
                            chan_cond.overcurrent, chan_cond.short_bat, chan_cond.open_load,
                            chan_cond.internal_uv | glob_cond.core_uv | glob_cond.bat_uv};
    assign sup_cond = {glob_cond.core_uv, glob_cond.bat_warn, glob_cond.bat_uv};
    assign global_clear = acc.global_rd | acc.summary_rd;
    assign serial_cond = glob_cond.serial_err & ~serial_error_mask; // see RULE_20
    assign wd_cond = glob_cond.watchdog_to & ~watchdog_error_mask; // see RULE_21

    // channel bits 15..9 cleared by a channel detail read
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN_BITS; gi++) begin : g_chan
            // reset value must be a constant, so take it straight from the reset word
            fault_flag_cell #(
                .RESET_VAL(FAULT_SUMMARY_RESET[BIT_SUPPLY + gi])
            ) u_cell (
                .clk(clk),
                .sys_rst(sys_rst),
                .cond(chan_cond_vec[gi]), // see RULE_02 RULE_04 RULE_05
                .latch_en(fault_latch_select),
                .clear_req(acc.chan_detail_rd), // see RULE_03
                .flag(chan_flag[gi]) // see RULE_06 RULE_07 RULE_08
            );
            a_chan_shown: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_05
                chan_cond_vec[gi] |-> ##2 status_r[BIT_SUPPLY + gi])
                else $error("channel fault not shown");
        end
        // supply bits 2..0 clear on a global read once the condition is gone
        for (gi = 0; gi < 3; gi++) begin : g_sup
            fault_flag_cell #(.RESET_VAL(FAULT_SUMMARY_RESET[gi])) u_cell ( // see RULE_16
                .clk(clk),
                .sys_rst(sys_rst),
                .cond(sup_cond[gi]),
                .latch_en(fault_latch_select),
                .clear_req(global_clear), // see RULE_17
                .flag(sup_flag[gi])
            );
            a_supply_shown: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_18
                sup_cond[gi] |-> ##2 status_r[gi])
                else $error("supply fault not shown");
        end
    endgenerate

    always_comb begin
        // serial errors latch regardless of the latch select
        serial_flag_nxt = serial_cond | (serial_flag_r & ~acc.summary_rd); // see RULE_15
        wd_flag_nxt = wd_cond | (wd_flag_r & ~acc.summary_rd); // see RULE_14
        // write-one-clear applies in either latch mode, set still wins
        if (glob_cond.fallback) begin
            fallback_nxt = 1'b1; // see RULE_11
        end else if (acc.summary_wr && acc.wdata[BIT_FALLBACK]) begin
            fallback_nxt = 1'b0;
        end else begin
            fallback_nxt = fallback_r;
        end
        // power-on only sets this at reset, so a read always clears it
        por_nxt = por_r & ~acc.summary_rd; // see RULE_12
        global_nxt = fallback_nxt | por_nxt | serial_flag_nxt | wd_flag_nxt
                     | (|sup_cond) | (|sup_flag); // see RULE_10
        if (fault_latch_select && !global_nxt && global_r && !global_clear) begin
            global_nxt = 1'b1;
        end
        status_nxt = 16'h0000;
        status_nxt[15:9] = chan_flag; // see RULE_09
        status_nxt[BIT_GLOBAL] = global_r;
        status_nxt[BIT_FALLBACK] = fallback_r;
        status_nxt[BIT_POR] = por_r;
        status_nxt[BIT_SERIAL_ERR] = serial_flag_r; // see RULE_13
        status_nxt[BIT_WATCHDOG] = wd_flag_r;
        status_nxt[2:0] = sup_flag; // see RULE_18
        // bit 5 stays zero; see RULE_19
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_flag_r <= FAULT_SUMMARY_RESET[BIT_SERIAL_ERR];
            wd_flag_r <= FAULT_SUMMARY_RESET[BIT_WATCHDOG];
            fallback_r <= FAULT_SUMMARY_RESET[BIT_FALLBACK];
            por_r <= FAULT_SUMMARY_RESET[BIT_POR];
            global_r <= FAULT_SUMMARY_RESET[BIT_GLOBAL];
            status_r <= FAULT_SUMMARY_RESET; // see RULE_01
        end else begin
            serial_flag_r <= serial_flag_nxt;
            wd_flag_r <= wd_flag_nxt;
            fallback_r <= fallback_nxt;
            por_r <= por_nxt;
            global_r <= global_nxt;
            status_r <= status_nxt;
        end
    end

    assign fault_summary_status = status_r;

    a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_19
        !status_r[5])
        else $error("reserved bit set");
    a_serial_mask: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_20
        serial_error_mask && !serial_flag_r ##1 serial_error_mask |-> !serial_flag_r)
        else $error("masked serial error recorded");
    a_wd_mask: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_21
        watchdog_error_mask && !wd_flag_r ##1 watchdog_error_mask |-> !wd_flag_r)
        else $error("masked watchdog error recorded");
    a_wd_latch: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_15
        wd_flag_r && !acc.summary_rd |=> wd_flag_r)
        else $error("watchdog flag lost without read");
    a_serial_set: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_13
        serial_cond |=> serial_flag_r ##1 status_r[BIT_SERIAL_ERR])
        else $error("serial error not shown");
    a_por_clear: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_12
        acc.summary_rd |=> !por_r ##1 !status_r[BIT_POR])
        else $error("power-on flag not cleared by read");
    a_fallback_live: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_11
        glob_cond.fallback |-> ##2 status_r[BIT_FALLBACK])
        else $error("fallback not shown");
    a_global_or: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_10
        (|status_r[7:0]) |-> status_r[BIT_GLOBAL])
        else $error("global summary low with global flag set");
    a_live_mode: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_22
        !fault_latch_select && !chan_cond.thermal ##1 !fault_latch_select
        |=> !status_r[BIT_THERMAL])
        else $error("thermal bit held without latching");
endmodule

// ### dv/host_model.sv
module host_model
    import fault_summary_pkg::*;
(
    input wire logic clk,
    output reg_access_t acc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] exp_q[$];
    initial acc = '0;
    // strobes last one cycle; a read notes the word expected at its edge
    task automatic rd(input logic [15:0] exp);
        @(negedge clk);
        acc.summary_rd = 1'b1;
        exp_q.push_back(exp);
        @(negedge clk);
        acc.summary_rd = 1'b0;
    endtask
    task automatic wr(input logic [15:0] d);
        @(negedge clk);
        acc.summary_wr = 1'b1;
        acc.wdata = d;
        @(negedge clk);
        acc.summary_wr = 1'b0;
        // stale data must not look like a held write
        acc.wdata = ~d;
    endtask
    task automatic side_rd();
        @(negedge clk);
        acc.chan_detail_rd = 1'b1;
        acc.global_rd = 1'b1;
        @(negedge clk);
        acc.chan_detail_rd = 1'b0;
        acc.global_rd = 1'b0;
    endtask
endmodule

// ### dv/tb.sv
module tb
    import fault_summary_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    chan_cond_t chan_cond = '0;
    glob_cond_t glob_cond = '0;
    reg_access_t acc;
    logic fault_latch_select = 1'b1;
    logic serial_error_mask = 1'b0;
    logic watchdog_error_mask = 1'b0;
    logic [15:0] fault_summary_status;
    int failures = 0;
    int comparisons = 0;
    int seed = 66;
    localparam logic [15:0] GEXP [5] = '{16'h0304, 16'h0102, 16'h0301, 16'h0110, 16'h0108};
    logic [2:0] knobs;
    logic [15:0] rexp;
    always #10 clk = ~clk;
    // word expected while the given levels are held, built field by field
    function automatic logic [15:0] exp_word(input chan_cond_t c, input glob_cond_t g,
        input logic sm, input logic wm);
        logic [15:0] w;
        w = 16'h0000;
        w[15:10] = c[6:1];
        w[BIT_SUPPLY] = c.internal_uv | g.core_uv | g.bat_uv;
        w[BIT_FALLBACK] = g.fallback;
        w[BIT_SERIAL_ERR] = g.serial_err & ~sm;
        w[BIT_WATCHDOG] = g.watchdog_to & ~wm;
        w[BIT_CORE_UV] = g.core_uv;
        w[BIT_BAT_WARN] = g.bat_warn;
        w[BIT_BAT_UV] = g.bat_uv;
        w[BIT_GLOBAL] = |w[7:0];
        return w;
    endfunction
    host_model i_host (.clk(clk), .acc(acc));
    fault_summary_status_register i_dut (.clk(clk), .sys_rst(sys_rst), .chan_cond(chan_cond),
        .glob_cond(glob_cond), .acc(acc), .fault_latch_select(fault_latch_select),
        .serial_error_mask(serial_error_mask), .watchdog_error_mask(watchdog_error_mask),
        .fault_summary_status(fault_summary_status));
    always @(posedge clk) begin
        if (!sys_rst && acc.summary_rd) begin
            comparisons++;
            if (i_host.exp_q.size() == 0) begin
                failures++;
                $display("[ERR] read note expected present seen none");
            end else if (fault_summary_status !== i_host.exp_q[0]) begin
                failures++;
                $display("[ERR] fault_summary_status expected %h seen %h",
                    i_host.exp_q[0], fault_summary_status);
            end
            if (i_host.exp_q.size() != 0) void'(i_host.exp_q.pop_front());
        end
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // the word shows a clear one cycle after the read's edge, so four gives margin
    task automatic clear_all();
        wait_n(4);
        i_host.side_rd();
        wait_n(4);
        i_host.rd(16'h0000);
    endtask
    task automatic por_test();
        sys_rst = 1'b1;
        wait_n(5);
        sys_rst = 1'b0;
        i_host.rd(FAULT_SUMMARY_RESET);
        clear_all();
        $display("test reset done");
    endtask
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        por_test();
        for (int i = 0; i < NUM_CHAN_BITS; i++) begin
            chan_cond = chan_cond_t'(7'h01 << i);
            wait_n(4);
            chan_cond = '0;
            wait_n(4);
            i_host.rd(16'h0001 << (i + 9));
            clear_all();
        end
        $display("test channel done");
        for (int j = 0; j < 5; j++) begin
            @(negedge clk) glob_cond = glob_cond_t'(6'h20 >> j);
            @(negedge clk) glob_cond = '0;
            wait_n(4);
            i_host.rd(GEXP[j]);
            clear_all();
        end
        glob_cond.core_uv = 1'b1;
        wait_n(4);
        i_host.rd(16'h0304);
        wait_n(4);
        i_host.rd(16'h0304);
        glob_cond = '0;
        wait_n(4);
        i_host.rd(16'h0304);
        clear_all();
        serial_error_mask = 1'b1;
        watchdog_error_mask = 1'b1;
        @(negedge clk) glob_cond = glob_cond_t'(6'h06);
        @(negedge clk) glob_cond = '0;
        wait_n(4);
        i_host.rd(16'h0000);
        serial_error_mask = 1'b0;
        watchdog_error_mask = 1'b0;
        $display("test global done");
        glob_cond.fallback = 1'b1;
        wait_n(4);
        i_host.rd(16'h0180);
        i_host.wr(16'h0080);
        wait_n(4);
        i_host.rd(16'h0180);
        glob_cond = '0;
        wait_n(4);
        i_host.wr(16'h0080);
        wait_n(4);
        i_host.rd(16'h0100);
        clear_all();
        $display("test fallback done");
        fault_latch_select = 1'b0;
        repeat (4) begin
            chan_cond = chan_cond_t'($random(seed));
            wait_n(4);
            i_host.rd({chan_cond, 9'h000});
            chan_cond = '0;
            wait_n(4);
            i_host.rd(16'h0000);
        end
        glob_cond.bat_warn = 1'b1;
        wait_n(4);
        i_host.rd(16'h0102);
        glob_cond = '0;
        wait_n(4);
        i_host.rd(16'h0000);
        fault_latch_select = 1'b1;
        $display("test follow done");
        // random levels, masks and latch mode; levels held, then dropped
        repeat (6) begin
            knobs = 3'($random(seed));
            fault_latch_select = knobs[0];
            serial_error_mask = knobs[1];
            watchdog_error_mask = knobs[2];
            chan_cond = chan_cond_t'(7'($random(seed)));
            glob_cond = glob_cond_t'(6'($random(seed)));
            wait_n(4);
            rexp = exp_word(chan_cond, glob_cond, knobs[1], knobs[2]);
            i_host.rd(rexp);
            chan_cond = '0;
            glob_cond = '0;
            wait_n(4);
            // live mode drops all but the always-latched and write-clear bits
            if (!knobs[0]) begin
                rexp = rexp & 16'h0098;
                rexp[BIT_GLOBAL] = |rexp[7:0];
            end
            i_host.rd(rexp);
            i_host.wr(16'h0080);
            clear_all();
        end
        fault_latch_select = 1'b1;
        serial_error_mask = 1'b0;
        watchdog_error_mask = 1'b0;
        $display("test random done");
        por_test();
        for (int k = 0; k < 20 && i_host.exp_q.size() != 0; k++) @(negedge clk);
        if (i_host.exp_q.size() != 0) failures++;
        close_out();
    end
endmodule
